// ===== core/sep_read_path.sv
// Overview of operation
// [R01] Master loads the address counter by a write select and address byte, no stop.
// [R02] Master then sends repeated start and select with read direction bit set.
// [R03] Matching read select is acknowledged, then the byte at the counter is sent.
// [R04] Counter advances by one after each byte fetched for output.
// [R05] Single-byte read: master withholds acknowledge then sends stop.
// [R06] Sequential read: master acknowledges, device sends the next address's byte.
// [R07] Streaming may follow current or random reads with no extra command.
// [R08] Master ends a stream by not acknowledging the last byte, then stop.
// [R09] Counter wraps from the highest location to 00h.
// [R10] High line at bit time 9 after a byte ends output; device goes idle.
// [R11] Every memory location reads FFh as delivered.
// [R12] Select bit eight: 1 means read, 0 means write.
// [R13] Reads ignore the write-guard input.
// [R14] Non-matching select releases the bus and returns to standby.
// [R15] Both 4-bit type and 3-bit strap address must match to respond.
// [R16] Data goes out MSB first, changing only while the serial clock is low.
`timescale 1ns/1ns
module sep_read_path
   import sep_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic link_clk,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic strap_addr_bit0,
   input wire logic strap_addr_bit1,
   input wire logic strap_addr_bit2,
   input wire logic write_guard_input,
   output logic rd_active
);
   typedef struct packed {
      sep_state_t st;
      logic scl_d;
      logic sda_d;
      logic [3:0] bit_cnt;
      logic [7:0] shift;
      logic is_addr;
      logic rw;
      logic mack_ok;
      logic req_tgl;
      logic cmd;
      logic [7:0] cmd_addr;
      logic ack_seen;
      logic [7:0] rx_data;
      logic sda_oe;
      logic active;
      logic [1:0] settle;
   } sep_link_t;

   typedef struct packed {
      logic req_seen;
      logic [SEP_ADDR_W-1:0] addr;
      logic pend;
      logic [7:0] pend_data;
      logic ack_tgl;
      logic [7:0] xfer;
      logic [3:0] hold;
      logic sda_lvl;
   } sep_sys_t;

   sep_link_t l_reg;
   sep_link_t l_next;
   sep_sys_t s_reg;
   sep_sys_t s_next;

   logic [SEP_PIN_W-1:0] pins_s;
   logic ack_s;
   logic req_s;
   logic buf_in_ready;
   logic buf_out_valid;
   logic buf_out_ready;
   logic [7:0] buf_out_data;
   logic [7:0] mem [SEP_MEM_DEPTH];

   // Serial pins and strap pins into the link clock
   sep_sync #(.W(SEP_PIN_W)) u_pin_sync (
      .clk(link_clk),
      .reset_n(reset_n),
      .d({scl_i, sda_i, strap_addr_bit2, strap_addr_bit1, strap_addr_bit0}),
      .q(pins_s)
   );

   // Byte delivery toggle into the link clock
   sep_sync #(.W(1)) u_ack_sync (
      .clk(link_clk),
      .reset_n(reset_n),
      .d(s_reg.ack_tgl),
      .q(ack_s)
   );

   // Load or fetch request toggle into the memory clock
   sep_sync #(.W(1)) u_req_sync (
      .clk(clk),
      .reset_n(reset_n),
      .d(l_reg.req_tgl),
      .q(req_s)
   );

   // Link side: bit-level protocol on the oversampling link clock
   always_comb begin
      logic scl;
      logic sda;
      logic rise;
      logic fall;
      logic start;
      logic stop;
      scl = pins_s[SEP_PIN_SCL];
      sda = pins_s[SEP_PIN_SDA];
      rise = scl && !l_reg.scl_d;
      fall = !scl && l_reg.scl_d;
      start = scl && l_reg.scl_d && l_reg.sda_d && !sda;
      stop = scl && l_reg.scl_d && !l_reg.sda_d && sda;
      // Synchroniser resets low while the bus idles high; ignore edges until it has flushed
      if (l_reg.settle != 2'h3) begin
         rise = 1'b0;
         fall = 1'b0;
         start = 1'b0;
         stop = 1'b0;
      end
      l_next = l_reg;
      l_next.scl_d = scl;
      l_next.sda_d = sda;
      if (l_reg.settle != 2'h3) begin
         l_next.settle = 2'(l_reg.settle + 1'b1);
      end
      if (ack_s != l_reg.ack_seen) begin
         l_next.ack_seen = ack_s;
         l_next.rx_data = s_reg.xfer;
      end
      if (start) begin
         l_next.st = SEP_ST_RX;
         l_next.bit_cnt = '0;
         l_next.is_addr = 1'b0;
         l_next.mack_ok = 1'b0;
         l_next.sda_oe = 1'b0;
         l_next.active = 1'b0;
      end else if (stop) begin
         l_next.st = SEP_ST_IDLE;
         l_next.sda_oe = 1'b0;
         l_next.active = 1'b0;
      end else begin
         case (l_reg.st)
            SEP_ST_RX: begin
               if (rise) begin
                  l_next.shift = {l_reg.shift[6:0], sda};
                  l_next.bit_cnt = 4'(l_reg.bit_cnt + 1'b1);
               end else if (fall && l_reg.bit_cnt == SEP_BYTE_BITS) begin
                  if (l_reg.is_addr) begin
                     l_next.cmd = SEP_CMD_LOAD; // [R01]
                     l_next.cmd_addr = l_reg.shift;
                     l_next.req_tgl = !l_reg.req_tgl;
                     l_next.st = SEP_ST_ACK;
                     l_next.sda_oe = 1'b1;
                  end else if (l_reg.shift[SEP_SEL_TYPE_MSB:SEP_SEL_TYPE_LSB] == SEP_DEV_TYPE &&
                               l_reg.shift[SEP_SEL_STRAP_MSB:SEP_SEL_STRAP_LSB] == pins_s[2:0]) begin // [R15]
                     l_next.rw = l_reg.shift[SEP_SEL_RW_BIT]; // [R12]
                     l_next.st = SEP_ST_ACK; // [R03]
                     l_next.sda_oe = 1'b1;
                     if (l_reg.shift[SEP_SEL_RW_BIT] == SEP_RW_READ) begin
                        l_next.cmd = SEP_CMD_FETCH; // [R02] [R07] [R13]
                        l_next.req_tgl = !l_reg.req_tgl;
                        l_next.active = 1'b1;
                     end
                  end else begin
                     l_next.st = SEP_ST_IDLE; // [R14]
                  end
               end
            end
            SEP_ST_ACK: begin
               if (fall) begin
                  l_next.bit_cnt = '0;
                  l_next.sda_oe = 1'b0;
                  if (l_reg.is_addr) begin
                     l_next.st = SEP_ST_IDLE;
                  end else if (l_reg.rw == SEP_RW_READ) begin
                     l_next.shift = l_reg.rx_data; // [R03]
                     l_next.sda_oe = !l_reg.rx_data[7]; // [R16]
                     l_next.st = SEP_ST_TX;
                  end else begin
                     l_next.is_addr = 1'b1;
                     l_next.st = SEP_ST_RX;
                  end
               end
            end
            SEP_ST_TX: begin
               if (fall) begin
                  if (l_reg.bit_cnt == SEP_LAST_TX_BIT) begin
                     l_next.sda_oe = 1'b0;
                     l_next.bit_cnt = '0;
                     l_next.st = SEP_ST_MACK;
                  end else begin
                     l_next.shift = {l_reg.shift[6:0], 1'b0}; // [R16]
                     l_next.sda_oe = !l_reg.shift[6];
                     l_next.bit_cnt = 4'(l_reg.bit_cnt + 1'b1);
                  end
               end
            end
            SEP_ST_MACK: begin
               if (rise) begin
                  if (sda) begin
                     l_next.st = SEP_ST_IDLE; // [R10] [R05] [R08]
                     l_next.active = 1'b0;
                  end else begin
                     l_next.mack_ok = 1'b1; // [R06]
                     l_next.cmd = SEP_CMD_FETCH;
                     l_next.req_tgl = !l_reg.req_tgl;
                  end
               end else if (fall && l_reg.mack_ok) begin
                  l_next.mack_ok = 1'b0;
                  l_next.shift = l_reg.rx_data; // [R06]
                  l_next.sda_oe = !l_reg.rx_data[7];
                  l_next.st = SEP_ST_TX;
               end
            end
            SEP_ST_IDLE: begin
               l_next.sda_oe = 1'b0;
            end
            default: begin
               l_next.st = SEP_ST_IDLE;
               l_next.sda_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         l_reg <= '{st: SEP_ST_IDLE, scl_d: 1'b1, sda_d: 1'b1, default: '0};
      end else begin
         l_reg <= l_next;
      end
   end

   // Memory side: array, address counter and byte delivery
   // Every location holds the erased value; nothing writes the array on this path
   for (genvar g = 0; g < SEP_MEM_DEPTH; g++) begin : g_mem
      always_ff @(posedge clk or negedge reset_n) begin
         if (!reset_n) begin
            mem[g] <= SEP_ERASED; // [R11]
         end
      end
   end

   always_comb begin
      s_next = s_reg;
      s_next.sda_lvl = 1'b0;
      if (s_reg.pend && buf_in_ready) begin
         s_next.pend = 1'b0;
      end
      // Request toggle from link side: load the counter or fetch a byte
      if (req_s != s_reg.req_seen) begin
         s_next.req_seen = req_s;
         if (l_reg.cmd == SEP_CMD_LOAD) begin
            s_next.addr = l_reg.cmd_addr; // [R01]
         end else begin
            s_next.pend = 1'b1;
            s_next.pend_data = mem[s_reg.addr]; // [R03]
            s_next.addr = (s_reg.addr == SEP_LAST_ADDR) ? SEP_WRAP_ADDR :
                          SEP_ADDR_W'(s_reg.addr + 1'b1); // [R04] [R09]
         end
      end
      // Deliver one byte, then keep it still while the link side picks it up
      if (buf_out_valid && buf_out_ready) begin
         s_next.xfer = buf_out_data;
         s_next.ack_tgl = !s_reg.ack_tgl;
         s_next.hold = SEP_HOLD_CYC;
      end else if (s_reg.hold != '0) begin
         s_next.hold = 4'(s_reg.hold - 1'b1);
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign buf_out_ready = (s_reg.hold == '0);

   sep_buf2 #(.W(8), .DEPTH(2)) u_buf (
      .clk(clk),
      .reset_n(reset_n),
      .in_valid(s_reg.pend),
      .in_ready(buf_in_ready),
      .in_data(s_reg.pend_data),
      .out_valid(buf_out_valid),
      .out_ready(buf_out_ready),
      .out_data(buf_out_data)
   );

   // Outputs come straight from registers
   assign sda_o = s_reg.sda_lvl;
   assign sda_oe = l_reg.sda_oe;
   assign rd_active = l_reg.active;
endmodule : sep_read_path

// ===== core/sep_pkg.sv
package sep_pkg;
   // Byte and select layout
   localparam int SEP_ADDR_W = 8;
   localparam int SEP_MEM_DEPTH = 256;
   localparam logic [SEP_ADDR_W-1:0] SEP_LAST_ADDR = 8'hff;
   localparam logic [SEP_ADDR_W-1:0] SEP_WRAP_ADDR = 8'h00;
   localparam logic [7:0] SEP_ERASED = 8'hff;
   // Device type identifier; the value is arbitrary
   localparam logic [3:0] SEP_DEV_TYPE = 4'h5;
   localparam int SEP_SEL_TYPE_MSB = 7;
   localparam int SEP_SEL_TYPE_LSB = 4;
   localparam int SEP_SEL_STRAP_MSB = 3;
   localparam int SEP_SEL_STRAP_LSB = 1;
   localparam int SEP_SEL_RW_BIT = 0;
   localparam logic SEP_RW_READ = 1'b1;
   localparam logic [3:0] SEP_BYTE_BITS = 4'h8;
   localparam logic [3:0] SEP_LAST_TX_BIT = 4'h7;
   // Commands from link side to memory side
   localparam logic SEP_CMD_FETCH = 1'b0;
   localparam logic SEP_CMD_LOAD = 1'b1;
   // Time a delivered byte stays alone in the crossing register
   localparam int SEP_CLK_NS = 20;
   localparam int SEP_HOLD_NS = 160;
   localparam logic [3:0] SEP_HOLD_CYC = 4'((SEP_HOLD_NS + SEP_CLK_NS - 1) / SEP_CLK_NS);
   // Pin vector positions
   localparam int SEP_PIN_SCL = 4;
   localparam int SEP_PIN_SDA = 3;
   localparam int SEP_PIN_W = 5;

   typedef enum logic [2:0] {
      SEP_ST_IDLE = 3'h0,
      SEP_ST_RX = 3'h1,
      SEP_ST_ACK = 3'h3,
      SEP_ST_TX = 3'h2,
      SEP_ST_MACK = 3'h6
   } sep_state_t;
endpackage : sep_pkg

// ===== core/sep_sync.sv
`timescale 1ns/1ns
module sep_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sep_sync_t;

   sep_sync_t r_reg;
   sep_sync_t r_next;

   always_comb begin
      r_next.s1 = d;
      r_next.s2 = r_reg.s1;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign q = r_reg.s2;
endmodule : sep_sync

// ===== core/sep_buf2.sv
`timescale 1ns/1ns
module sep_buf2 #(
   parameter int W = 8,
   parameter int DEPTH = 2
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);
   localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [PW-1:0] wr;
      logic [PW-1:0] rd;
      logic [CW-1:0] cnt;
   } sep_buf_t;

   sep_buf_t b_reg;
   sep_buf_t b_next;
   logic push;
   logic pop;

   always_comb begin
      b_next = b_reg;
      push = in_valid && (b_reg.cnt != FULL);
      pop = out_ready && (b_reg.cnt != '0);
      if (push) begin
         b_next.mem[b_reg.wr] = in_data;
         b_next.wr = (b_reg.wr == LAST) ? '0 : PW'(b_reg.wr + 1'b1);
      end
      if (pop) begin
         b_next.rd = (b_reg.rd == LAST) ? '0 : PW'(b_reg.rd + 1'b1);
      end
      if (push && !pop) begin
         b_next.cnt = CW'(b_reg.cnt + 1'b1);
      end else if (pop && !push) begin
         b_next.cnt = CW'(b_reg.cnt - 1'b1);
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         b_reg <= '0;
      end else begin
         b_reg <= b_next;
      end
   end

   assign in_ready = (b_reg.cnt != FULL);
   assign out_valid = (b_reg.cnt != '0);
   assign out_data = b_reg.mem[b_reg.rd];
endmodule : sep_buf2

// ===== verification/sep_read_path_asserts.sv
`timescale 1ns/1ns
module sep_read_path_asserts
   import sep_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic link_clk,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe,
   input wire logic rd_active
);
   default clocking cb @(posedge link_clk); endclocking
   default disable iff (!reset_n);
   logic [5:0] idle_cnt_reg;
   // Counts link cycles of an idle bus, both lines high
   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         idle_cnt_reg <= 6'h00;
      end else if (scl_i && sda_i) begin
         if (idle_cnt_reg != 6'h3f) begin
            idle_cnt_reg <= idle_cnt_reg + 6'h01;
         end
      end else begin
         idle_cnt_reg <= 6'h00;
      end
   end
   chk_open_drain: assert property (sda_o == 1'b0)
      else $error("data pin output not low");
   chk_edge_scl_low: assert property ($changed(sda_oe) |-> !scl_i)
      else $error("data line changed while serial clock high");
   chk_drive_settled: assert property ($rose(sda_oe) |-> $past(scl_i, 2) == 1'b0)
      else $error("data driven too soon after clock fall");
   chk_drive_holds: assert property ($rose(sda_oe) |=> sda_oe [*8])
      else $error("acknowledge not held");
   chk_select_ack: assert property ($rose(rd_active) |-> !scl_i ##[0:2] sda_oe)
      else $error("read select not acknowledged");
   chk_end_release: assert property ($fell(rd_active) |-> !sda_oe)
      else $error("line held after read end");
   chk_end_scl_high: assert property ($fell(rd_active) |-> scl_i)
      else $error("read ended outside a clock high phase");
   chk_idle_standby: assert property (idle_cnt_reg == 6'h30 |-> !rd_active && !sda_oe)
      else $error("device active on idle bus");
   cover property ($rose(rd_active));
   cover property ($fell(rd_active));
   cover property (idle_cnt_reg == 6'h30);
endmodule : sep_read_path_asserts

// ===== verification/sep_master_model.sv
`timescale 1ns/1ns
module sep_master_model (
   output logic scl,
   output logic sda_drv,
   input wire logic sda
);
   localparam int QTR = 600;
   logic [7:0] res;
   event res_ev;
   initial begin
      scl = 1'b1;
      sda_drv = 1'b0;
   end
   task automatic bit_io(input logic b, output logic s);
      sda_drv = !b;
      #QTR scl = 1'b1;
      #QTR s = sda;
      #QTR scl = 1'b0;
      #QTR;
   endtask : bit_io
   // Start or repeated start, no stop before it
   task automatic start_c;
      sda_drv = 1'b0;
      #QTR scl = 1'b1;
      #QTR sda_drv = 1'b1;
      #QTR scl = 1'b0;
      #QTR;
   endtask : start_c
   task automatic stop_c;
      sda_drv = 1'b1;
      #QTR scl = 1'b1;
      #QTR sda_drv = 1'b0;
      #(4*QTR);
   endtask : stop_c
   // Sends a byte MSB first; reports the acknowledge slot level
   task automatic put_byte(input logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], s);
      end
      bit_io(1'b1, s);
      res = {7'h00, s};
      -> res_ev;
   endtask : put_byte
   // Reads a byte; acknowledges it only when more are wanted
   task automatic get_byte(input logic ack);
      logic s;
      logic [7:0] d;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, s);
         d[i] = s;
      end
      bit_io(!ack, s);
      res = d;
      -> res_ev;
   endtask : get_byte
endmodule : sep_master_model

// ===== verification/sep_read_path_tb.sv
`timescale 1ns/1ns
module sep_read_path_tb;
   import sep_pkg::*;
   logic clk, link_clk, reset_n, guard, dut_oe, dut_o, rd_active, m_scl, m_drv;
   logic [2:0] strap, s;
   logic [7:0] a, sel;
   logic [7:0] exp_q[$];
   int miscompares, compares;
   wire sda_w = !(dut_oe || m_drv);
   sep_read_path i_dut (.clk(clk), .reset_n(reset_n), .link_clk(link_clk), .scl_i(m_scl), .sda_i(sda_w),
      .sda_o(dut_o), .sda_oe(dut_oe), .strap_addr_bit0(strap[0]), .strap_addr_bit1(strap[1]),
      .strap_addr_bit2(strap[2]), .write_guard_input(guard), .rd_active(rd_active));
   sep_master_model i_m (.scl(m_scl), .sda_drv(m_drv), .sda(sda_w));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      link_clk = 1'b0;
      #7;
      forever #16 link_clk = ~link_clk;
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic report_and_stop;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      forever begin
         @(i_m.res_ev);
         check(i_m.res, exp_q.pop_front());
      end
   end
   task automatic drive_pins(input logic [2:0] st, input logic g);
      @(posedge clk);
      #2;
      strap = st;
      guard = g;
   endtask : drive_pins
   // Read select, n bytes all acknowledged but the last, then stop
   task automatic read_seq(input logic [7:0] sl, input int n);
      exp_q.push_back(8'h00);
      i_m.start_c();
      i_m.put_byte(sl);
      for (int k = 0; k < n; k++) begin
         exp_q.push_back(SEP_ERASED);
         i_m.get_byte(k < n - 1);
      end
      i_m.stop_c();
      check({7'h00, rd_active}, 8'h00);
   endtask : read_seq
   initial begin
      void'($urandom(32'h63817272));
      reset_n = 1'b0;
      strap = 3'h0;
      guard = 1'b0;
      repeat (8) @(posedge clk);
      #2;
      reset_n = 1'b1;
      #1000;
      drive_pins(3'h5, 1'b1);
      read_seq({SEP_DEV_TYPE, 3'h5, 1'b1}, 1);
      $display("current read done");
      for (int t = 0; t < 3; t++) begin
         s = 3'($urandom);
         a = (t == 0) ? 8'hfe : 8'($urandom);
         drive_pins(s, 1'($urandom));
         exp_q.push_back(8'h00);
         exp_q.push_back(8'h00);
         i_m.start_c();
         i_m.put_byte({SEP_DEV_TYPE, s, 1'b0});
         i_m.put_byte(a);
         read_seq({SEP_DEV_TYPE, s, 1'b1}, 4);
      end
      $display("random sequential reads done");
      for (int t = 0; t < 4; t++) begin
         sel = {SEP_DEV_TYPE, strap, 1'b1} ^ (8'h02 << t);
         exp_q.push_back(8'h01);
         i_m.start_c();
         i_m.put_byte(sel);
         i_m.stop_c();
         check({7'h00, rd_active}, 8'h00);
      end
      $display("mismatched selects done");
      read_seq({SEP_DEV_TYPE, strap, 1'b1}, 3);
      $display("sequential current read done");
      #1000;
      check(8'(exp_q.size()), 8'h00);
      report_and_stop();
   end
   initial begin
      #1500000;
      miscompares++;
      report_and_stop();
   end
endmodule : sep_read_path_tb
bind sep_read_path sep_read_path_asserts i_chk (.clk(clk), .reset_n(reset_n), .link_clk(link_clk),
   .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .rd_active(rd_active));
